// File: src/ast_async_serial_transceiver.sv
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps

module ast_async_serial_transceiver
  import ast_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [31:0] awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [31:0] araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  input  wire logic        rx_data_pin_in,
  output logic             tx_clock_pin_out,
  output logic             tx_clock_pin_oe_out
);

  // Address hit on one register word, upper bits must be zero
  function automatic logic addr_hit(input logic [31:0] a, input logic [4:0] off);
    addr_hit = (a[OFF_W-1:0] == off) && (a[31:OFF_W] == '0);
  endfunction

  // Byte-lane merge for write strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    strb_merge = r;
  endfunction

  // Two-of-three vote
  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  // Bus side state
  logic [31:0]   awaddr_q;       // Latched write address
  logic          aw_full_q;      // Write address held
  logic [31:0]   wdata_q;        // Latched write data
  logic [3:0]    wstrb_q;        // Latched strobes
  logic          w_full_q;       // Write data held
  logic          bvalid_q;       // Write response pending
  logic [1:0]    bresp_q;        // Write response code
  logic          rvalid_q;       // Read response pending
  logic [1:0]    rresp_q;        // Read response code
  logic [31:0]   rdata_q;        // Read data
  logic [31:0]   rd_mux;         // Read data before register

  // Software registers
  ast_ctrl_t     ctrl_q;         // Control bits
  logic [15:0]   baud_q;         // baud_divider_pair
  ast_status_t   status;         // Assembled status word

  // Baud tick generator
  logic [15:0]   baud_cnt_q;     // System clocks within one tick
  logic [1:0]    prescale_q;     // Low-speed extra divide
  logic          tick_q;         // Sixteen-times oversample pulse
  logic [15:0]   divider;        // Effective divisor

  // Transmitter
  logic          tx_active;      // Transmitter enabled in async
  logic          tx_write;       // Software writes tx_buffer
  logic [8:0]    tx_buffer_q;    // Held character, ninth bit on top
  logic          tx_buf_nine_q;  // Held character is nine bits
  logic          tx_buf_full_q;  // A character is queued
  logic [10:0]   tx_shift_q;     // tx_shift_register, LSB goes out
  logic [3:0]    tx_bits_q;      // Bits left in frame
  logic [3:0]    tx_tick_q;      // Ticks within current bit
  logic          tx_busy_q;      // Shifter holds a character
  logic          tx_done;        // Last tick of stop bit
  logic          load_buf;       // Queued character enters shifter
  logic          load_direct;    // Written character enters shifter
  logic          empty_s0_q;     // Empty flag pipeline stage
  logic          empty_s1_q;     // Empty flag as software sees it
  logic          tx_pin_q;       // Registered line level

  // Receiver
  logic          rx_active;      // Receiver enabled in async
  ast_rx_state_t rx_state_q;     // Data recovery state
  logic [3:0]    rx_tick_q;      // Ticks within current bit
  logic [1:0]    rx_smp_q;       // Early vote samples
  logic [3:0]    rx_bits_q;      // Data bits taken so far
  logic [8:0]    rx_shift_q;     // rx_shift_register
  logic          rx_prev_q;      // Line level one clock ago
  logic          vote;           // Majority level of current bit
  logic          decide;         // Bit centre reached this cycle
  logic          rx_push;        // Complete character ready
  logic          push_ok;        // FIFO accepts the character
  logic          pop;            // Software reads rx_data_register
  logic          overrun_q;      // overrun_flag
  ast_rx_entry_t fifo_q [2];     // Receive FIFO storage
  logic          wr_ptr_q;       // FIFO write index
  logic          rd_ptr_q;       // FIFO read index
  logic [1:0]    fifo_cnt_q;     // Entries held
  ast_rx_entry_t fifo_top;       // Oldest entry
  ast_rx_entry_t rx_entry;       // Entry being pushed

  // Write handshakes: address and data accepted in either order
  assign awready_out = !aw_full_q && !bvalid_q;
  assign wready_out  = !w_full_q && !bvalid_q;
  assign bvalid_out  = bvalid_q;
  assign bresp_out   = bresp_q;
  assign arready_out = !rvalid_q;
  assign rvalid_out  = rvalid_q;
  assign rresp_out   = rresp_q;
  assign rdata_out   = rdata_q;

  // Write channel latches and response
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      if (awvalid_in && awready_out)
      begin
        aw_full_q <= 1'b1;
        awaddr_q  <= awaddr_in;
      end
      if (wvalid_in && wready_out)
      begin
        w_full_q <= 1'b1;
        wdata_q  <= wdata_in;
        wstrb_q  <= wstrb_in;
      end
      // Both halves present: commit, then answer
      if (aw_full_q && w_full_q && !bvalid_q)
      begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        if (addr_hit(awaddr_q, OFF_CTRL) || addr_hit(awaddr_q, OFF_BAUD) ||
            addr_hit(awaddr_q, OFF_TXDATA))
          bresp_q <= RESP_OKAY;
        else
          bresp_q <= RESP_SLVERR;
      end
      else if (bvalid_q && bready_in)
        bvalid_q <= 1'b0;
    end
  end

  // Control and divider registers with byte strobes
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ctrl_q <= CTRL_RESET;
      baud_q <= BAUD_RESET;
    end
    else if (aw_full_q && w_full_q && !bvalid_q)
    begin
      if (addr_hit(awaddr_q, OFF_CTRL))
        ctrl_q <= ast_ctrl_t'(11'(strb_merge({21'h0, ctrl_q}, wdata_q, wstrb_q)));
      if (addr_hit(awaddr_q, OFF_BAUD))
        baud_q <= 16'(strb_merge({16'h0, baud_q}, wdata_q, wstrb_q));
    end
  end

  // Status word; status bits are read-only
  always_comb
  begin
    status.tx_empty_flag      = empty_s1_q;
    status.shift_reg_empty    = !tx_busy_q;
    status.rx_ready_flag      = rx_active && (fifo_cnt_q != 2'h0);
    status.framing_error_flag = (fifo_cnt_q != 2'h0) && fifo_top.framing_err;
    status.overrun_flag       = overrun_q;
    status.tx_irq_request     = empty_s1_q && ctrl_q.tx_irq_enable;
    status.rx_top_ninth_bit   = (fifo_cnt_q != 2'h0) && fifo_top.data[8];
  end

  // Read mux; shift register and FIFO have no address of their own
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (addr_hit(araddr_in, OFF_CTRL))
      rd_mux = {21'h0, ctrl_q};
    else if (addr_hit(araddr_in, OFF_BAUD))
      rd_mux = {16'h0, baud_q};
    else if (addr_hit(araddr_in, OFF_RXDATA))
      rd_mux = {23'h0, fifo_top.data};
    else if (addr_hit(araddr_in, OFF_STATUS))
      rd_mux = {25'h0, status};
  end

  // Read channel; a read of the data register pops the FIFO
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else if (arvalid_in && arready_out)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      if (addr_hit(araddr_in, OFF_CTRL) || addr_hit(araddr_in, OFF_BAUD) ||
          addr_hit(araddr_in, OFF_RXDATA) || addr_hit(araddr_in, OFF_STATUS))
        rresp_q <= RESP_OKAY;
      else
        rresp_q <= RESP_SLVERR;
    end
    else if (rvalid_q && rready_in)
      rvalid_q <= 1'b0;
  end

  // narrow divider uses low byte only
  assign divider = ctrl_q.baud_wide_divider_select ? baud_q : {8'h00, baud_q[7:0]};

  // Tick every divider+1 clocks, times four in low-speed mode
  // one tick paces both halves
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      baud_cnt_q <= '0;
      prescale_q <= '0;
      tick_q     <= 1'b0;
    end
    else if (!ctrl_q.serial_port_enable)
    begin
      baud_cnt_q <= '0;
      prescale_q <= '0;
      tick_q     <= 1'b0;
    end
    else if (baud_cnt_q >= divider)
    begin
      baud_cnt_q <= '0;
      if (ctrl_q.baud_high_speed_select || prescale_q == LOW_PRESCALE)
      begin
        prescale_q <= '0;
        tick_q     <= 1'b1;
      end
      else
      begin
        prescale_q <= prescale_q + 2'h1;
        tick_q     <= 1'b0;
      end
    end
    else
    begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  assign tx_active   = ctrl_q.serial_port_enable && ctrl_q.tx_enable_bit &&
                       !ctrl_q.sync_mode_select;
  assign tx_write    = aw_full_q && w_full_q && !bvalid_q &&
                       addr_hit(awaddr_q, OFF_TXDATA) && wstrb_q[0];
  assign tx_done     = tx_busy_q && tick_q && (tx_tick_q == TICK_LAST) &&
                       (tx_bits_q == 4'h1);
  assign load_buf    = tx_active && tx_buf_full_q && (!tx_busy_q || tx_done);
  assign load_direct = tx_active && tx_write && !tx_busy_q && !tx_buf_full_q;

  // Transmit buffer; a write while one is queued replaces it
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      tx_buffer_q   <= '0;
      tx_buf_nine_q <= 1'b0;
      tx_buf_full_q <= 1'b0;
    end
    else if (!tx_active)
      tx_buf_full_q <= 1'b0;
    else if (tx_write && !load_direct)
    begin
      tx_buffer_q   <= {ctrl_q.tx_ninth_bit, wdata_q[7:0]};
      tx_buf_nine_q <= ctrl_q.tx_nine_bit_select;
      tx_buf_full_q <= 1'b1;
    end
    else if (load_buf)
      tx_buf_full_q <= 1'b0;
  end

  // Shifter: sixteen ticks per bit, LSB first, stop bit last
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      tx_shift_q <= '1;
      tx_bits_q  <= '0;
      tx_tick_q  <= '0;
      tx_busy_q  <= 1'b0;
    end
    else if (!tx_active)
    begin
      tx_busy_q <= 1'b0;
      tx_tick_q <= '0;
    end
    else if (load_buf)
    begin
      tx_shift_q <= {1'b1, tx_buf_nine_q ? tx_buffer_q[8] : 1'b1,
                     tx_buffer_q[7:0], 1'b0};
      tx_bits_q  <= tx_buf_nine_q ? FRAME_9 : FRAME_8;
      tx_tick_q  <= '0;
      tx_busy_q  <= 1'b1;
    end
    else if (load_direct)
    begin
      tx_shift_q <= {1'b1, ctrl_q.tx_nine_bit_select ? ctrl_q.tx_ninth_bit : 1'b1,
                     wdata_q[7:0], 1'b0};
      tx_bits_q  <= ctrl_q.tx_nine_bit_select ? FRAME_9 : FRAME_8;
      tx_tick_q  <= '0;
      tx_busy_q  <= 1'b1;
    end
    else if (tx_busy_q && tick_q)
    begin
      tx_tick_q <= tx_tick_q + 4'h1;
      if (tx_tick_q == TICK_LAST)
      begin
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
        tx_bits_q  <= tx_bits_q - 4'h1;
        if (tx_bits_q == 4'h1)
          tx_busy_q <= 1'b0;
      end
    end
  end

  // Line driver; level held between equal bits, no return to neutral
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      tx_pin_q <= 1'b1;
    else
      tx_pin_q <= (tx_busy_q ? tx_shift_q[0] : 1'b1) ^ ctrl_q.tx_polarity_select;
  end

  assign tx_clock_pin_out    = tx_pin_q;
  assign tx_clock_pin_oe_out = ctrl_q.serial_port_enable;

  // Empty flag two-stage pipe; reads right after a write may be stale
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      empty_s0_q <= 1'b0;
      empty_s1_q <= 1'b0;
    end
    else
    begin
      empty_s0_q <= tx_active && !tx_buf_full_q;
      empty_s1_q <= empty_s0_q;
    end
  end

  assign rx_active = ctrl_q.serial_port_enable && ctrl_q.rx_continuous_enable &&
                     !ctrl_q.sync_mode_select;
  assign decide    = tick_q && (rx_tick_q == SMP_DECIDE);
  assign vote      = majority(rx_smp_q[1], rx_smp_q[0], rx_data_pin_in);
  assign rx_push   = rx_active && !overrun_q && (rx_state_q == RX_STOP) && decide;

  // Previous line level for falling-edge search
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      rx_prev_q <= 1'b1;
    else
      rx_prev_q <= rx_data_pin_in;
  end

  // Data recovery; overrun parks the receiver in hunt
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rx_state_q <= RX_HUNT;
      rx_tick_q  <= '0;
      rx_smp_q   <= '0;
      rx_bits_q  <= '0;
      rx_shift_q <= '0;
    end
    else if (!rx_active || overrun_q)
    begin
      rx_state_q <= RX_HUNT;
      rx_tick_q  <= '0;
    end
    else
    begin
      case (rx_state_q)
        RX_HUNT:
        begin
          if (rx_prev_q && !rx_data_pin_in)
          begin
            rx_state_q <= RX_START;
            rx_tick_q  <= '0;
          end
        end
        default:
        begin
          if (tick_q)
          begin
            rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_tick_q == SMP_FIRST || rx_tick_q == SMP_SECOND)
              rx_smp_q <= {rx_smp_q[0], rx_data_pin_in};
          end
          if (decide)
          begin
            case (rx_state_q)
              RX_START:
              begin
                rx_bits_q <= '0;
                rx_state_q <= vote ? RX_HUNT : RX_DATA;
              end
              RX_DATA:
              begin
                rx_shift_q <= {vote, rx_shift_q[8:1]};
                rx_bits_q  <= rx_bits_q + 4'h1;
                if (rx_bits_q == (ctrl_q.rx_nine_bit_select ? DATA_9_LAST : DATA_8_LAST))
                  rx_state_q <= RX_STOP;
              end
              default:
                rx_state_q <= RX_HUNT;
            endcase
          end
        end
      endcase
    end
  end

  // Entry to store; eight-bit characters sit low
  always_comb
  begin
    rx_entry.data        = ctrl_q.rx_nine_bit_select ? rx_shift_q : {1'b0, rx_shift_q[8:1]};
    rx_entry.framing_err = !vote;
  end

  assign fifo_top = fifo_q[rd_ptr_q];
  assign pop      = arvalid_in && arready_out && addr_hit(araddr_in, OFF_RXDATA) &&
                    (fifo_cnt_q != 2'h0);
  assign push_ok  = rx_push && ((fifo_cnt_q != 2'h2) || pop);

  // FIFO pointers and count; port disable flushes it
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_ptr_q   <= 1'b0;
      rd_ptr_q   <= 1'b0;
      fifo_cnt_q <= '0;
    end
    else if (!ctrl_q.serial_port_enable)
    begin
      wr_ptr_q   <= 1'b0;
      rd_ptr_q   <= 1'b0;
      fifo_cnt_q <= '0;
    end
    else
    begin
      if (push_ok)
        wr_ptr_q <= !wr_ptr_q;
      if (pop)
        rd_ptr_q <= !rd_ptr_q;
      if (push_ok && !pop)
        fifo_cnt_q <= fifo_cnt_q + 2'h1;
      else if (pop && !push_ok)
        fifo_cnt_q <= fifo_cnt_q - 2'h1;
    end
  end

  // FIFO storage, one flop word per entry
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_fifo
      always_ff @(posedge clk_in or posedge reset_in)
      begin
        if (reset_in)
          fifo_q[i] <= '0;
        else if (push_ok && (wr_ptr_q == 1'(i)))
          fifo_q[i] <= rx_entry;
      end
    end
  endgenerate

  // Overrun: set wins, cleared only by disabling the receiver
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      overrun_q <= 1'b0;
    else if (rx_push && !push_ok)
      overrun_q <= 1'b1;
    else if (!rx_active)
      overrun_q <= 1'b0;
  end

endmodule // ast_async_serial_transceiver

// File: src/ast_pkg.sv
package ast_pkg;

  // Register byte offsets
  localparam logic [4:0]  OFF_CTRL     = 5'h00;
  localparam logic [4:0]  OFF_BAUD     = 5'h04;
  localparam logic [4:0]  OFF_TXDATA   = 5'h08;
  localparam logic [4:0]  OFF_RXDATA   = 5'h0C;
  localparam logic [4:0]  OFF_STATUS   = 5'h10;
  localparam int          OFF_W        = 5;

  // Reset values
  localparam logic [10:0] CTRL_RESET   = 11'h000;
  localparam logic [15:0] BAUD_RESET   = 16'h0000;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Oversampling: ticks per bit, vote sample points
  localparam logic [3:0]  TICK_LAST    = 4'hF;
  localparam logic [3:0]  SMP_FIRST    = 4'h7;
  localparam logic [3:0]  SMP_SECOND   = 4'h8;
  localparam logic [3:0]  SMP_DECIDE   = 4'h9;
  // Low-speed mode divides the tick rate by four more
  localparam logic [1:0]  LOW_PRESCALE = 2'h3;

  // Frame lengths in bits, start and stop included; index of the last data bit
  localparam logic [3:0]  FRAME_8      = 4'hA;
  localparam logic [3:0]  FRAME_9      = 4'hB;
  localparam logic [3:0]  DATA_8_LAST  = 4'h7;
  localparam logic [3:0]  DATA_9_LAST  = 4'h8;

  // Control register, bit 0 is serial_port_enable
  typedef struct packed {
    logic tx_ninth_bit;
    logic tx_irq_enable;
    logic baud_wide_divider_select;
    logic baud_high_speed_select;
    logic rx_nine_bit_select;
    logic rx_continuous_enable;
    logic tx_nine_bit_select;
    logic tx_polarity_select;
    logic sync_mode_select;
    logic tx_enable_bit;
    logic serial_port_enable;
  } ast_ctrl_t;

  // Status register, bit 0 is tx_empty_flag
  typedef struct packed {
    logic rx_top_ninth_bit;
    logic tx_irq_request;
    logic overrun_flag;
    logic framing_error_flag;
    logic rx_ready_flag;
    logic shift_reg_empty;
    logic tx_empty_flag;
  } ast_status_t;

  // One receive FIFO entry
  typedef struct packed {
    logic       framing_err;
    logic [8:0] data;
  } ast_rx_entry_t;

  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP} ast_rx_state_t;

endpackage

// File: test/ast_async_serial_transceiver_bench.sv
`timescale 1ns/1ps
bind ast_async_serial_transceiver ast_sva CHK (.clk_in(clk_in), .reset_in(reset_in),
  .awvalid_in(awvalid_in), .awready_out(awready_out), .wvalid_in(wvalid_in),
  .wready_out(wready_out), .bvalid_out(bvalid_out), .bready_in(bready_in),
  .araddr_in(araddr_in), .arvalid_in(arvalid_in), .arready_out(arready_out),
  .rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out),
  .rready_in(rready_in), .tx_clock_pin_out(tx_clock_pin_out));
module ast_async_serial_transceiver_bench;
  import ast_pkg::*;
  logic        clk_in, reset_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
  logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic        rx_data_pin_in, tx_clock_pin_out, tx_clock_pin_oe_out;
  logic [31:0] awaddr_in, wdata_in, araddr_in, rdata_out;
  logic [3:0]  wstrb_in;
  logic [1:0]  bresp_out, rresp_out;
  int          n_mismatch = 0;
  int          tests_run = 0;
  ast_async_serial_transceiver DUT (.clk_in, .reset_in, .awaddr_in, .awvalid_in,
    .awready_out, .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out,
    .bready_in, .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out,
    .rvalid_out, .rready_in, .rx_data_pin_in, .tx_clock_pin_out, .tx_clock_pin_oe_out);
  ast_peer PEER (.clk_in(clk_in), .line_in(tx_clock_pin_out), .line_out(rx_data_pin_in));
  // 50 ns period
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Address and data offered together, bready held until the answer
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_in);
    awaddr_in <= {27'h0, a};
    wdata_in <= d;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (awready_out) awvalid_in <= 1'b0;
      if (wready_out) wvalid_in <= 1'b0;
    end
    while (bvalid_out !== 1'b1 && n < 100);
    bready_in <= 1'b0;
    cmp("bresp", {29'h0, 1'b1, er}, {29'h0, bvalid_out, bresp_out});
  endtask
  // Read one word and compare it
  task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge clk_in);
    araddr_in <= {27'h0, a};
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (arready_out) arvalid_in <= 1'b0;
    end
    while (rvalid_out !== 1'b1 && n < 100);
    rready_in <= 1'b0;
    cmp("rvalid", 32'h1, {31'h0, rvalid_out});
    cmp(nm, exp, rdata_out);
  endtask
  task automatic t_regs;
    rdc("ctrl", OFF_CTRL, {21'h0, CTRL_RESET});
    rdc("baud", OFF_BAUD, {16'h0, BAUD_RESET});
    rdc("status", OFF_STATUS, 32'h2);
    rdc("unmapped", 5'h14, 32'h0);
    wr(OFF_STATUS, 32'h1, RESP_SLVERR);
    wr(OFF_BAUD, 32'h1234, RESP_OKAY);
    rdc("baud", OFF_BAUD, 32'h1234);
    wr(OFF_BAUD, 32'h0, RESP_OKAY);
    $display("t_regs done");
  endtask
  task automatic t_tx8;
    logic [8:0] d;
    logic       s;
    wr(OFF_CTRL, 32'h283, RESP_OKAY);
    cmp("oe", 32'h1, {31'h0, tx_clock_pin_oe_out});
    cmp("idle", 32'h1, {31'h0, tx_clock_pin_out});
    repeat (2) @(posedge clk_in);
    rdc("status", OFF_STATUS, 32'h23);
    fork
      begin
        wr(OFF_TXDATA, 32'hA5, RESP_OKAY);
        wr(OFF_TXDATA, 32'h3C, RESP_OKAY);
        wr(OFF_CTRL, 32'h83, RESP_OKAY);
        repeat (2) @(posedge clk_in);
        rdc("status", OFF_STATUS, 32'h0);
      end
      begin
        PEER.get_char(8, 1'b0, d, s);
        cmp("tx0", 32'h2A5, {22'h0, s, d});
        PEER.get_char(8, 1'b0, d, s);
        cmp("tx1", 32'h23C, {22'h0, s, d});
      end
    join
    repeat (16) @(posedge clk_in);
    rdc("status", OFF_STATUS, 32'h3);
    $display("t_tx8 done");
  endtask
  task automatic t_tx9;
    logic [8:0] d;
    logic       s;
    wr(OFF_BAUD, 32'h100, RESP_OKAY);
    wr(OFF_CTRL, 32'h41B, RESP_OKAY);
    repeat (16) @(posedge clk_in);
    cmp("idle", 32'h0, {31'h0, tx_clock_pin_out});
    PEER.bitc = 64;
    fork
      wr(OFF_TXDATA, 32'h3C, RESP_OKAY);
      PEER.get_char(9, 1'b1, d, s);
    join
    cmp("tx9", 32'h33C, {22'h0, s, d});
    repeat (64) @(posedge clk_in);
    $display("t_tx9 done");
  endtask
  task automatic t_rx;
    PEER.bitc = 16;
    wr(OFF_BAUD, 32'h0, RESP_OKAY);
    wr(OFF_CTRL, 32'hA1, RESP_OKAY);
    PEER.send_char(9'h05A, 8, 1'b1);
    PEER.send_char(9'h033, 8, 1'b0);
    PEER.send_char(9'h077, 8, 1'b1);
    rdc("status", OFF_STATUS, 32'h16);
    rdc("rx0", OFF_RXDATA, 32'h5A);
    rdc("status", OFF_STATUS, 32'h1E);
    rdc("rx1", OFF_RXDATA, 32'h33);
    wr(OFF_CTRL, 32'h81, RESP_OKAY);
    wr(OFF_CTRL, 32'hA5, RESP_OKAY);
    PEER.send_char(9'h011, 8, 1'b1);
    wr(OFF_CTRL, 32'hE1, RESP_OKAY);
    PEER.glitch;
    PEER.send_char(9'h10F, 9, 1'b1);
    rdc("status", OFF_STATUS, 32'h46);
    rdc("rx2", OFF_RXDATA, 32'h10F);
    rdc("status", OFF_STATUS, 32'h2);
    $display("t_rx done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Inputs idle from time zero, reset for two clocks
  initial
  begin
    reset_in = 1'b1;
    awaddr_in = 32'h0;
    wdata_in = 32'h0;
    wstrb_in = 4'hF;
    araddr_in = 32'h0;
    {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 5'h00;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    t_regs;
    t_tx8;
    t_tx9;
    t_rx;
    final_report;
  end
  // Whole run is a few thousand clocks; a hang ends here
  initial
  begin
    #500000;
    n_mismatch++;
    final_report;
  end
endmodule // ast_async_serial_transceiver_bench

// File: test/ast_peer.sv
`timescale 1ns/1ps
// Far-end peer: frames characters onto receive line, decodes transmit line
module ast_peer
(
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  int bitc = 16; // Clocks per bit, set by the bench
  initial line_out = 1'b1;
  task automatic send_char(input logic [8:0] d, input int nb, input logic stp);
    @(posedge clk_in);
    line_out <= 1'b0;
    for (int i = 0; i <= nb; i++)
    begin
      repeat (bitc) @(posedge clk_in);
      line_out <= (i == nb) ? stp : d[i];
    end
    repeat (bitc) @(posedge clk_in);
    line_out <= 1'b1;
    repeat (bitc) @(posedge clk_in);
  endtask
  // Short low pulse, too brief to pass for a start bit
  task automatic glitch;
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    line_out <= 1'b1;
    repeat (2 * bitc) @(posedge clk_in);
  endtask
  // idle level, then sample each bit centre
  task automatic get_char(input int nb, input logic pol, output logic [8:0] d,
                          output logic stp);
    int n;
    n = 0;
    d = 9'h000;
    while ((line_in ^ pol) === 1'b1 && n < 4000)
    begin
      @(posedge clk_in);
      n++;
    end
    repeat (bitc / 2) @(posedge clk_in);
    for (int i = 0; i < nb; i++)
    begin
      repeat (bitc) @(posedge clk_in);
      d[i] = line_in ^ pol;
    end
    repeat (bitc) @(posedge clk_in);
    stp = line_in ^ pol;
  endtask
endmodule // ast_peer

// File: test/ast_sva.sv
`timescale 1ns/1ps
// Port checks: bus handshakes and serial bit timing
module ast_sva
  import ast_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        awvalid_in,
  input wire logic        awready_out,
  input wire logic        wvalid_in,
  input wire logic        wready_out,
  input wire logic        bvalid_out,
  input wire logic        bready_in,
  input wire logic [31:0] araddr_in,
  input wire logic        arvalid_in,
  input wire logic        arready_out,
  input wire logic [31:0] rdata_out,
  input wire logic [1:0]  rresp_out,
  input wire logic        rvalid_out,
  input wire logic        rready_in,
  input wire logic        tx_clock_pin_out
);
  logic [7:0] run_q; // Clocks since the line last moved
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Saturating, so long idle spans never wrap into a false short bit
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in) run_q <= 8'hFF;
    else if ($changed(tx_clock_pin_out)) run_q <= 8'h00;
    else if (run_q != 8'hFF) run_q <= run_q + 8'h01;
  a_bit_width: assert property ($changed(tx_clock_pin_out) |-> run_q >= 8'h0F)
    else $error("serial bit shorter than sixteen clocks");
  a_read_lat: assert property (arvalid_in && arready_out |=> rvalid_out)
    else $error("read answer late");
  a_read_hold: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
    else $error("read data dropped early");
  a_ar_gate: assert property (arready_out == !rvalid_out)
    else $error("read address ready wrong");
  a_write_resp: assert property (awvalid_in && awready_out && wvalid_in && wready_out
    |=> ##1 bvalid_out) else $error("write answer late");
  a_write_block: assert property (bvalid_out |-> !awready_out && !wready_out)
    else $error("write accepted during response");
  a_write_hold: assert property (bvalid_out && !bready_in |=> bvalid_out)
    else $error("write response dropped early");
  a_unmapped_rd: assert property (arvalid_in && arready_out && araddr_in[31:5] == 27'h0
    && araddr_in[4:2] > 3'h4 |=> rresp_out == RESP_SLVERR && rdata_out == 32'h0)
    else $error("unmapped read not refused");
endmodule // ast_sva
